// *** common/rt_record_consts.svh ***
`ifndef RT_RECORD_CONSTS_SVH
`define RT_RECORD_CONSTS_SVH
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RECORD 4'h8
`define REG_INFO 4'hC
`define CTRL_BCAST 0
`define CTRL_CMD_WE 1
`define CTRL_REC_WE 2
`define CTRL_RESET 3'h7
`define RX_PREFIX 6'h00
`define TX_PREFIX 6'h1F
`define BCAST_ADDR 5'h1F
`define MODE_SA_LO 5'h00
`define MODE_SA_HI 5'h1F
`define CLK_MHZ 32'h0000_0064
`define MEM_TIMEOUT_NS 32'h0000_03E8
`define MEM_TIMEOUT_CYC ((`MEM_TIMEOUT_NS * `CLK_MHZ) / 32'h0000_03E8)
`endif

// *** common/rt_record_pkg.sv ***
`default_nettype none
package rt_record_pkg;
	typedef struct packed {
		logic [4:0] rt_addr;
		logic tx;
		logic [4:0] sub_addr;
		logic [4:0] count;
	} cmd_word_type;
	typedef struct packed {
		logic msg_err;
		logic echo_err_b;
		logic echo_err_a;
		logic illegal;
		logic line_code_err;
		logic parity_err;
		logic count_err;
		logic [4:0] word_count;
	} msg_result_type;
	typedef struct packed {
		logic [4:0] rt_addr;
		logic subsys;
		logic busy;
		logic flag;
	} strap_type;
	typedef enum logic [1:0] {OPER_CMD, OPER_DATA, OPER_REC} mem_oper_type;
	typedef enum logic {MEM_IDLE, MEM_BUSY} mem_state_type;
	typedef struct packed {
		strap_type strap1;
		strap_type strap2;
		logic [2:0] ctrl;
		cmd_word_type cmd;
		logic cmd_bus;
		logic cmd_bcast;
		logic msg_err;
		logic mem_fail;
		logic addr_latch;
		logic vec_latch;
		logic [6:0] vector;
		logic [15:0] status_word;
		logic [15:0] record;
		logic pend_cmd;
		logic pend_data;
		logic pend_rec;
		logic data_wr;
		logic [10:0] data_addr;
		logic [15:0] data_wdata;
		logic data_done;
		logic data_fail;
		logic [15:0] data_rdata;
		mem_state_type mstate;
		mem_oper_type oper;
		logic mem_req;
		logic mem_wr;
		logic [10:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [7:0] timer;
		logic waitreq;
		logic [31:0] rdata;
	} state_type;
endpackage
`default_nettype wire

// *** rtl/rt_status_and_transfer_record.sv ***
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rt_record_consts.svh"
module rt_status_and_transfer_record (
	// clock, reset, enable
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	// avalon-mm slave
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// terminal pins
	input wire logic [4:0] TERMINAL_ADDRESS_I,
	input wire logic SUBSYSTEM_FLAG_I,
	input wire logic TERMINAL_BUSY_I,
	input wire logic TERMINAL_FLAG_I,
	// protocol side
	input wire logic MSG_START_I,
	input wire logic [15:0] CMD_WORD_I,
	input wire logic CMD_BUS_I,
	input wire logic MSG_ERROR_I,
	input wire logic FLAG_INHIBIT_I,
	input wire logic MSG_END_I,
	input wire rt_record_pkg::msg_result_type MSG_RESULT_I,
	input wire logic DATA_REQ_I,
	input wire logic DATA_WR_I,
	input wire logic [10:0] DATA_ADDR_I,
	input wire logic [15:0] DATA_WDATA_I,
	output logic DATA_DONE_O,
	output logic DATA_FAIL_O,
	output logic [15:0] DATA_RDATA_O,
	output logic [15:0] STATUS_WORD_O,
	// backend memory
	output logic MEM_REQ_O,
	output logic MEM_WR_O,
	output logic [10:0] MEM_ADDR_O,
	output logic [15:0] MEM_WDATA_O,
	output logic [1:0] MEM_OPER_O,
	input wire logic MEM_ACK_I,
	input wire logic [15:0] MEM_RDATA_I,
	// mapper and vector hooks
	output logic [15:0] COMMAND_VALID_O,
	output logic ADDRESS_LATCH_STROBE_O,
	output logic VECTOR_LATCH_STROBE_O,
	output logic [6:0] VECTOR_O
);
	localparam logic [7:0] TIMEOUT_LAST =
		8'(`MEM_TIMEOUT_CYC - 32'h0000_0001);

	rt_record_pkg::state_type st;
	rt_record_pkg::state_type next_st;
	rt_record_pkg::cmd_word_type cin;
	rt_record_pkg::msg_result_type res;
	logic cmd_evt;
	logic rec_evt;
	logic take_cmd;
	logic take_data;
	logic take_rec;
	logic ack_now;
	logic fail_now;
	logic mode_sa;
	logic bus_req;
	logic [15:0] rec_word;
	logic [15:0] sw;
	logic [31:0] rd;

	assign cin = rt_record_pkg::cmd_word_type'(CMD_WORD_I);
	assign res = MSG_RESULT_I;

	always_comb begin
		mode_sa = (st.cmd.sub_addr == `MODE_SA_LO) ||
			(st.cmd.sub_addr == `MODE_SA_HI);
		// built from the latched command so late pulses cannot skew it
		rec_word = 16'h0000;
		rec_word[15] = 1'b1;
		rec_word[13] = st.cmd_bus;
		rec_word[12] = st.cmd_bcast;
		rec_word[11] = res.echo_err_b;
		rec_word[10] = res.echo_err_a;
		rec_word[9] = res.illegal;
		// a failure in this very cycle still reaches the record
		rec_word[8] = st.mem_fail | fail_now;
		rec_word[7] = res.line_code_err;
		rec_word[6] = res.parity_err;
		rec_word[5] = res.count_err;
		rec_word[14] = ~|rec_word[11:5];
		// count wraps: 0 means 32 words unless count error
		rec_word[4:0] = mode_sa ? st.cmd.count :
			res.word_count;
	end

	always_comb begin
		sw = 16'h0000;
		sw[15:11] = st.strap2.rt_addr;
		sw[10] = st.msg_err | MSG_ERROR_I;
		sw[8] = st.strap2.subsys;
		sw[4] = st.cmd_bcast;
		sw[3] = st.strap2.busy;
		sw[2] = st.strap2.subsys;
		sw[0] = st.strap2.flag & ~FLAG_INHIBIT_I;
		// bits 9, 7:5 and 1 stay zero: never a bus controller
	end

	always_comb begin
		rd = 32'h0000_0000;
		case (AVS_ADDRESS_I)
			`REG_CTRL: rd[2:0] = st.ctrl;
			`REG_STATUS: rd[15:0] = st.status_word;
			`REG_RECORD: rd[15:0] = st.record;
			`REG_INFO: begin
				rd[6:0] = st.vector;
				rd[8] = st.pend_cmd;
				rd[9] = st.pend_data;
				rd[10] = st.pend_rec;
				rd[11] = st.mstate == rt_record_pkg::MEM_BUSY;
				rd[12] = st.mem_fail;
			end
			default: rd = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.addr_latch = 1'b0;
		next_st.vec_latch = 1'b0;
		next_st.data_done = 1'b0;
		next_st.strap1 = {TERMINAL_ADDRESS_I, SUBSYSTEM_FLAG_I,
			TERMINAL_BUSY_I, TERMINAL_FLAG_I};
		next_st.strap2 = st.strap1;
		next_st.status_word = sw;

		// avalon: one wait cycle, answer in the next
		bus_req = AVS_READ_I | AVS_WRITE_I;
		next_st.waitreq = ~(bus_req & st.waitreq);
		if (bus_req & st.waitreq) begin
			next_st.rdata = AVS_READ_I ? rd : 32'h0000_0000;
		end
		if (AVS_WRITE_I && !st.waitreq && AVS_BYTEENABLE_I[0] &&
			AVS_ADDRESS_I == `REG_CTRL) begin
			next_st.ctrl = AVS_WRITEDATA_I[2:0];
		end

		// command capture at transfer start
		if (MSG_START_I) begin
			next_st.cmd = cin;
			next_st.cmd_bus = CMD_BUS_I;
			next_st.cmd_bcast = st.ctrl[`CTRL_BCAST] &&
				cin.rt_addr == `BCAST_ADDR;
			next_st.msg_err = 1'b0;
			next_st.mem_fail = 1'b0;
			next_st.addr_latch = 1'b1;
		end
		if (MSG_ERROR_I) begin
			next_st.msg_err = 1'b1;
		end

		// memory sequencer
		cmd_evt = MSG_START_I & st.ctrl[`CTRL_CMD_WE];
		rec_evt = MSG_END_I & st.ctrl[`CTRL_REC_WE];
		take_cmd = 1'b0;
		take_data = 1'b0;
		take_rec = 1'b0;
		ack_now = 1'b0;
		fail_now = 1'b0;
		case (st.mstate)
			rt_record_pkg::MEM_IDLE: begin
				// command first so a transmit fetch follows it
				if (st.pend_cmd) begin
					take_cmd = 1'b1;
					next_st.oper = rt_record_pkg::OPER_CMD;
					next_st.mem_wr = 1'b1;
					next_st.mem_addr = {st.cmd.tx ? `TX_PREFIX :
						`RX_PREFIX, st.cmd.sub_addr};
					next_st.mem_wdata = st.cmd;
				end else if (st.pend_data) begin
					take_data = 1'b1;
					next_st.oper = rt_record_pkg::OPER_DATA;
					next_st.mem_wr = st.data_wr;
					next_st.mem_addr = st.data_addr;
					next_st.mem_wdata = st.data_wdata;
				end else if (st.pend_rec) begin
					take_rec = 1'b1;
					next_st.oper = rt_record_pkg::OPER_REC;
					next_st.mem_wr = 1'b1;
					next_st.mem_addr = {st.cmd.tx ? `TX_PREFIX :
						`RX_PREFIX, st.cmd.sub_addr};
					next_st.mem_wdata = st.record;
				end
				if (take_cmd | take_data | take_rec) begin
					next_st.mem_req = 1'b1;
					next_st.timer = 8'h00;
					next_st.mstate = rt_record_pkg::MEM_BUSY;
				end
			end
			rt_record_pkg::MEM_BUSY: begin
				if (MEM_ACK_I) begin
					ack_now = 1'b1;
				end else if (st.timer == TIMEOUT_LAST) begin
					// abort keeps each slot at 1 us
					fail_now = 1'b1;
				end else begin
					next_st.timer = st.timer + 8'h01;
				end
				if (ack_now | fail_now) begin
					next_st.mem_req = 1'b0;
					next_st.mstate = rt_record_pkg::MEM_IDLE;
					if (st.oper == rt_record_pkg::OPER_DATA) begin
						next_st.data_done = 1'b1;
						next_st.data_fail = fail_now;
						next_st.data_rdata = MEM_RDATA_I;
					end
				end
			end
			default: begin
				next_st.mem_req = 1'b0;
				next_st.mstate = rt_record_pkg::MEM_IDLE;
			end
		endcase
		if (fail_now) begin
			next_st.mem_fail = 1'b1;
		end

		// new event wins over the slot being taken
		next_st.pend_cmd = (st.pend_cmd & ~take_cmd) | cmd_evt;
		next_st.pend_rec = (st.pend_rec & ~take_rec) | rec_evt;
		next_st.pend_data = (st.pend_data & ~take_data) | DATA_REQ_I;
		if (DATA_REQ_I) begin
			next_st.data_wr = DATA_WR_I;
			next_st.data_addr = DATA_ADDR_I;
			next_st.data_wdata = DATA_WDATA_I;
		end

		// transfer end: record and vector
		if (MSG_END_I) begin
			// last data then record, two 1 us slots
			next_st.record = rec_word;
			// spare top bit left zero for an external vector extension
			next_st.vector = {1'h0, st.cmd.tx,
				st.cmd.sub_addr};
			next_st.vec_latch = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			st <= '0;
			st.ctrl <= `CTRL_RESET;
			st.waitreq <= 1'b1;
		end else if (CE_I) begin
			st <= next_st;
		end
	end

	assign AVS_READDATA_O = st.rdata;
	assign AVS_WAITREQUEST_O = st.waitreq;
	assign DATA_DONE_O = st.data_done;
	assign DATA_FAIL_O = st.data_fail;
	assign DATA_RDATA_O = st.data_rdata;
	assign STATUS_WORD_O = st.status_word;
	assign MEM_REQ_O = st.mem_req;
	assign MEM_WR_O = st.mem_wr;
	assign MEM_ADDR_O = st.mem_addr;
	assign MEM_WDATA_O = st.mem_wdata;
	assign MEM_OPER_O = st.oper;
	assign COMMAND_VALID_O = st.cmd;
	assign ADDRESS_LATCH_STROBE_O = st.addr_latch;
	assign VECTOR_LATCH_STROBE_O = st.vec_latch;
	assign VECTOR_O = st.vector;

	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);

	a_sw_address: assert property (
		$past(CE_I) |-> STATUS_WORD_O[15:11] == $past(st.strap2.rt_addr))
		else $error("status address field wrong");
	a_sw_zero_bits: assert property (
		STATUS_WORD_O[9] == 1'b0 && STATUS_WORD_O[7:5] == 3'h0 &&
		STATUS_WORD_O[1] == 1'b0)
		else $error("status fixed bits not zero");
	a_sw_subsys_pair: assert property (
		STATUS_WORD_O[8] == STATUS_WORD_O[2])
		else $error("status subsystem bits differ");
	a_sw_flag_inhibit: assert property (
		CE_I && FLAG_INHIBIT_I |=> STATUS_WORD_O[0] == 1'b0)
		else $error("terminal flag not inhibited");
	a_rec_no_error_bit_bit: assert property (
		MEM_REQ_O && st.oper == rt_record_pkg::OPER_REC |->
		MEM_WDATA_O[15] && MEM_WDATA_O[14] == ~|MEM_WDATA_O[11:5])
		else $error("record no_error_bit or used bit wrong");
	a_rec_address: assert property (
		MEM_REQ_O && st.oper != rt_record_pkg::OPER_DATA |->
		MEM_ADDR_O[4:0] == st.cmd.sub_addr &&
		MEM_ADDR_O[10:5] == (st.cmd.tx ? `TX_PREFIX : `RX_PREFIX))
		else $error("record address wrong");
	a_cmd_skip: assert property (
		CE_I && MSG_START_I && !st.ctrl[`CTRL_CMD_WE] && !st.pend_cmd
		|=> !st.pend_cmd)
		else $error("command write not skipped");
	a_timeout_abort: assert property (
		CE_I && MEM_REQ_O && !MEM_ACK_I && st.timer == TIMEOUT_LAST
		|=> !MEM_REQ_O && st.mem_fail)
		else $error("memory access not aborted");
	a_vector_latch: assert property (
		CE_I && MSG_END_I |=> VECTOR_LATCH_STROBE_O &&
		VECTOR_O == $past({1'h0, st.cmd.tx, st.cmd.sub_addr}))
		else $error("vector not latched");
	a_addr_latch: assert property (
		CE_I && MSG_START_I |=> ADDRESS_LATCH_STROBE_O &&
		COMMAND_VALID_O == $past(CMD_WORD_I))
		else $error("command not presented on latch");

	c_cmd_write: cover property (
		MEM_REQ_O && st.oper == rt_record_pkg::OPER_CMD ##1 MEM_ACK_I);
	c_data_read: cover property (DATA_DONE_O && !DATA_FAIL_O);
	c_timeout: cover property (DATA_DONE_O && DATA_FAIL_O);
	c_record_write: cover property (
		MEM_REQ_O && st.oper == rt_record_pkg::OPER_REC && st.cmd_bcast);
endmodule
`default_nettype wire

// *** test/rt_backend_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rt_backend_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// access from the block
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic [10:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [1:0] oper_i,
	input wire logic [7:0] lat_i,
	output logic ack_o,
	output logic [15:0] rdata_o,
	// write log for the bench
	output logic [10:0] log_addr_o,
	output logic [15:0] log_data_o,
	output logic [1:0] log_oper_o,
	output logic [7:0] log_count_o
);
	logic [7:0] cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'h0;
			cnt <= 8'h00;
			rdata_o <= 16'h0000;
			log_count_o <= 8'h00;
		end else if (!req_i || ack_o) begin
			ack_o <= 1'h0;
			cnt <= 8'h00;
			// no stale word between answers
			rdata_o <= ~rdata_o;
		end else if (cnt == lat_i && lat_i != 8'hFF) begin
			// answer once cnt reaches lat_i; 8'hFF never answers
			ack_o <= 1'h1;
			rdata_o <= {addr_i[7:0], 8'h5A};
			if (wr_i) begin
				log_addr_o <= addr_i;
				log_data_o <= wdata_i;
				log_oper_o <= oper_i;
				log_count_o <= log_count_o + 8'h01;
			end
		end else begin
			cnt <= cnt + 8'h01;
			rdata_o <= ~rdata_o;
		end
	end
endmodule
`default_nettype wire

// *** test/tb_rt_status_and_transfer_record.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_rt_status_and_transfer_record;
	logic clk, rst_n, rd, wr, start, stop, err, inh, dreq, dwr, bus;
	logic ce;
	logic ss, busy, flg, wq, done, fail, mreq, mwr, ack, als, vls;
	logic [3:0] adr;
	logic [31:0] wd, q, rdata;
	logic [4:0] ta;
	logic [15:0] cmd, ddat, drd, sw, mwd, mrd, cv, ld;
	logic [10:0] dadr, madr, la;
	logic [7:0] lat, lc;
	logic [1:0] moper, lo;
	logic [6:0] vec;
	rt_record_pkg::msg_result_type res;
	int bad_count, check_count;

	rt_status_and_transfer_record dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.CE_I(ce), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq),
		.TERMINAL_ADDRESS_I(ta), .SUBSYSTEM_FLAG_I(ss),
		.TERMINAL_BUSY_I(busy), .TERMINAL_FLAG_I(flg), .MSG_START_I(start),
		.CMD_WORD_I(cmd), .CMD_BUS_I(bus), .MSG_ERROR_I(err),
		.FLAG_INHIBIT_I(inh), .MSG_END_I(stop), .MSG_RESULT_I(res),
		.DATA_REQ_I(dreq), .DATA_WR_I(dwr), .DATA_ADDR_I(dadr),
		.DATA_WDATA_I(ddat), .DATA_DONE_O(done), .DATA_FAIL_O(fail),
		.DATA_RDATA_O(drd), .STATUS_WORD_O(sw), .MEM_REQ_O(mreq),
		.MEM_WR_O(mwr), .MEM_ADDR_O(madr), .MEM_WDATA_O(mwd),
		.MEM_OPER_O(moper), .MEM_ACK_I(ack), .MEM_RDATA_I(mrd),
		.COMMAND_VALID_O(cv), .ADDRESS_LATCH_STROBE_O(als),
		.VECTOR_LATCH_STROBE_O(vls), .VECTOR_O(vec));
	rt_backend_model bm (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq),
		.wr_i(mwr), .addr_i(madr), .wdata_i(mwd), .oper_i(moper),
		.lat_i(lat), .ack_o(ack), .rdata_o(mrd), .log_addr_o(la),
		.log_data_o(ld), .log_oper_o(lo), .log_count_o(lc));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// holds the request until waitrequest is seen low at a rising edge
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wq !== 1'h0 && k < 50);
		chk(k < 50, 1'h1);
		r = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask

	task automatic rst_test;
		@(negedge clk);
		chk(wq, 1'h1);
		chk(mreq, 1'h0);
		av(1'h0, 4'h0, 32'h0000_0000, q);
		chk(q, 32'h0000_0007);
		// unmapped place: write lost, reads zero
		av(1'h1, 4'h1, 32'h0000_00FF, q);
		av(1'h0, 4'h1, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		$display("test reset done");
	endtask

	// pins move while enable is low: status must not follow
	task automatic ce_test;
		logic [15:0] h;
		logic [4:0] t;
		h = sw;
		t = ~h[15:11];
		@(posedge clk);
		ce <= 1'h0;
		ta <= t;
		repeat (6) @(negedge clk);
		chk(sw, h);
		@(posedge clk);
		ce <= 1'h1;
		repeat (5) @(negedge clk);
		chk(sw[15:11], t);
		$display("test clock enable done");
	endtask

	task automatic st(input logic [4:0] a, input logic s, input logic b,
		input logic f, input logic i, input logic e, input logic bc);
		logic [15:0] x;
		x = {a, e, 1'h0, s, 3'h0, bc, b, s, 1'h0, f & ~i};
		@(posedge clk);
		ta <= a;
		ss <= s;
		busy <= b;
		flg <= f;
		inh <= i;
		err <= e;
		@(posedge clk);
		err <= 1'h0;
		repeat (5) @(negedge clk);
		chk(sw[15:8], x[15:8]);
		chk(sw[7:0], x[7:0]);
		av(1'h0, 4'h4, 32'h0000_0000, q);
		chk(q, {16'h0000, x});
		$display("test status done");
	endtask

	task automatic ms(input logic [15:0] c, input logic b, input logic we,
		input logic bc);
		logic [7:0] n;
		n = lc;
		@(posedge clk);
		start <= 1'h1;
		cmd <= c;
		bus <= b;
		@(posedge clk);
		start <= 1'h0;
		@(negedge clk);
		chk(als, 1'h1);
		chk(cv, c);
		repeat (30) @(negedge clk);
		chk(lc, n + we);
		if (we) begin
			chk(lo, 2'h0);
			chk(la, {c[10] ? 6'h1F : 6'h00, c[9:5]});
			chk(ld, c);
		end
		chk(sw[4], bc);
		$display("test message start done");
	endtask

	task automatic me(input logic [15:0] c, input logic b,
		input rt_record_pkg::msg_result_type r, input logic we,
		input logic bc, input logic mf);
		logic [7:0] n;
		logic [15:0] e;
		logic m;
		n = lc;
		m = c[9:5] == 5'h00 || c[9:5] == 5'h1F;
		e = {1'h1, ~|{r[10:5], mf}, b, bc, r[10:8], mf, r[7:5],
			m ? c[4:0] : r[4:0]};
		@(posedge clk);
		stop <= 1'h1;
		res <= r;
		@(posedge clk);
		stop <= 1'h0;
		@(negedge clk);
		chk(vls, 1'h1);
		chk(vec, {c[10], c[9:5]});
		repeat (30) @(negedge clk);
		chk(lc, n + we);
		if (we) begin
			chk(lo, 2'h2);
			chk(la, {c[10] ? 6'h1F : 6'h00, c[9:5]});
			chk(ld[15:12], e[15:12]);
			chk(ld[11:8], e[11:8]);
			chk(ld[7:0], e[7:0]);
		end
		$display("test message done");
	endtask

	task automatic dt(input logic w, input logic [10:0] a,
		input logic [7:0] l, input logic f);
		int k;
		@(posedge clk);
		lat <= l;
		dreq <= 1'h1;
		dwr <= w;
		dadr <= a;
		ddat <= {5'h00, a};
		@(posedge clk);
		dreq <= 1'h0;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (done !== 1'h1 && k < 300);
		chk(fail, f);
		if (f)
			chk(k > 99 && k < 106, 1'h1);
		else if (w)
			chk({lo, la, ld}, {2'h1, a, 5'h00, a});
		else
			chk(drd, {a[7:0], 8'h5A});
		lat <= 8'h02;
		$display("test data access done");
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim;
	end

	initial begin
		logic [15:0] c;
		{rd, wr, start, stop, err, inh, dreq, dwr, bus, ss, busy, flg} = '0;
		{adr, wd, ta, cmd, ddat, dadr, res} = '0;
		lat = 8'h02;
		ce = 1'h1;
		rst_n = 1'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		rst_test;
		st(5'h15, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
		st(5'h0A, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
		st(5'h0A, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
		ce_test;
		c = {5'h0A, 1'h0, 5'h03, 5'h00};
		ms(c, 1'h0, 1'h1, 1'h0);
		dt(1'h1, 11'h045, 8'h01, 1'h0);
		me(c, 1'h0, 12'h000, 1'h1, 1'h0, 1'h0);
		c = {5'h0A, 1'h1, 5'h18, 5'h04};
		ms(c, 1'h1, 1'h1, 1'h0);
		dt(1'h0, 11'h304, 8'h00, 1'h0);
		me(c, 1'h1, 12'h245, 1'h1, 1'h0, 1'h0);
		c = {5'h1F, 1'h0, 5'h00, 5'h02};
		ms(c, 1'h0, 1'h1, 1'h1);
		me(c, 1'h0, 12'h000, 1'h1, 1'h1, 1'h0);
		av(1'h1, 4'h0, 32'h0000_0006, q);
		ms(c, 1'h0, 1'h1, 1'h0);
		me(c, 1'h0, 12'h121, 1'h1, 1'h0, 1'h0);
		av(1'h1, 4'h0, 32'h0000_0001, q);
		c = {5'h0A, 1'h0, 5'h01, 5'h03};
		ms(c, 1'h0, 1'h0, 1'h0);
		me(c, 1'h0, 12'h003, 1'h0, 1'h0, 1'h0);
		av(1'h1, 4'h0, 32'h0000_0006, q);
		ms(c, 1'h1, 1'h1, 1'h0);
		dt(1'h0, 11'h010, 8'hFF, 1'h1);
		me(c, 1'h1, 12'h483, 1'h1, 1'h0, 1'h1);
		end_sim;
	end
endmodule
`default_nettype wire
